// >>> design/hdc_consts.svh
`ifndef HDC_CONSTS_SVH
`define HDC_CONSTS_SVH

// Register map and field layout
`define HDC_REG_ADDR    8'h1b
`define HDC_BOOST_BIT   7
`define HDC_AC_BIT      5
`define HDC_DT_MSB      4
`define HDC_BOOST_RST   1'b1
`define HDC_AC_RST      1'b0
`define HDC_DT_RST      5'h13
`define HDC_GAIN_RST    2'h2
`define HDC_RD_UNMAPPED 8'h00

// Bus address of this device; the value is arbitrary
`define HDC_DEV_ADDR    7'h2c
`define HDC_BITS_BYTE   4'h8

// Timing: one step is the common unit of every drive and sample period
`define HDC_CLK_KHZ     20000
`define HDC_STEP_US     100
`define HDC_STEP_CYC    ((`HDC_STEP_US * `HDC_CLK_KHZ) / 1000)
`define HDC_LRA_UNIT_US 100
`define HDC_LRA_BASE_US 500
`define HDC_ERM_UNIT_US 200
`define HDC_ERM_BASE_US 1000
`define HDC_PERIOD_MIN  7'h01
`define HDC_PERIOD_MAX  7'h7f

// Back-EMF amplifier gain in hundredths, per actuator type
`define HDC_ERM_GAIN0   12'h021
`define HDC_ERM_GAIN1   12'h064
`define HDC_ERM_GAIN2   12'h0b4
`define HDC_ERM_GAIN3   12'h190
`define HDC_LRA_GAIN0   12'h1f4
`define HDC_LRA_GAIN1   12'h3e8
`define HDC_LRA_GAIN2   12'h7d0
`define HDC_LRA_GAIN3   12'hbb8

`endif

// >>> design/hdc_pkg.sv
package hdc_pkg;

	typedef enum logic [3:0] {
		HDC_IDLE, HDC_ADDR, HDC_ADDR_ACK, HDC_PTR, HDC_PTR_ACK,
		HDC_WDATA, HDC_WDATA_ACK, HDC_RDATA, HDC_RACK
	} hdc_i2c_st_t;

	typedef struct packed {
		hdc_i2c_st_t st;
		logic [7:0]  sh;
		logic [3:0]  cnt;
		logic [7:0]  ptr;
		logic        rw;
		logic        drv;
		logic        wr;
		logic        scl_s1;
		logic        scl_s2;
		logic        scl_d;
		logic        sda_s1;
		logic        sda_s2;
		logic        sda_d;
	} hdc_i2c_t;

	typedef struct packed {
		logic        boost;
		logic        ac;
		logic [4:0]  dt;
		logic [1:0]  gain;
		logic [11:0] gain_x100;
		logic        running;
		logic [6:0]  period;
		logic [10:0] step;
		logic [6:0]  pcnt;
		logic        tick;
	} hdc_top_t;

endpackage

// >>> design/hdc_regbus_if.sv
`timescale 1ns/1ps
interface hdc_regbus_if;
	logic       wr_valid;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;

	modport master (output wr_valid, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport regs   (input wr_valid, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// >>> design/hdc_i2c_slave.sv
`timescale 1ns/1ps
`include "hdc_consts.svh"
module hdc_i2c_slave (
	input  wire logic         sys_clk_i,
	input  wire logic         resetn_i,
	input  wire logic         scl_i,
	input  wire logic         sda_i,
	output wire logic         sda_o,
	output wire logic         sda_oe_o,
	hdc_regbus_if.master      bus
);
	localparam hdc_pkg::hdc_i2c_t RST = '{st: hdc_pkg::HDC_IDLE, sh: 8'h00, cnt: 4'h0, ptr: 8'h00,
		rw: 1'b0, drv: 1'b0, wr: 1'b0, scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
		sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1};

	hdc_pkg::hdc_i2c_t r;
	hdc_pkg::hdc_i2c_t next_r;
	logic              rise;
	logic              fall;
	logic              start;
	logic              stop;

	// Edges come from the second sync stage and its delayed copy only
	assign rise  = r.scl_s2 & ~r.scl_d;
	assign fall  = ~r.scl_s2 & r.scl_d;
	assign start = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
	assign stop  = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;

	// Open drain: the line is only ever pulled low
	assign sda_o        = 1'b0;
	assign sda_oe_o     = r.drv;
	assign bus.wr_valid = r.wr;
	assign bus.wr_addr  = r.ptr;
	assign bus.wr_data  = r.sh;
	assign bus.rd_addr  = r.ptr;

	// Byte engine: shift on rising clock, drive on falling clock
	always_comb begin
		next_r        = r;
		next_r.wr     = 1'b0;
		next_r.scl_s1 = scl_i;
		next_r.scl_s2 = r.scl_s1;
		next_r.scl_d  = r.scl_s2;
		next_r.sda_s1 = sda_i;
		next_r.sda_s2 = r.sda_s1;
		next_r.sda_d  = r.sda_s2;
		if (start) begin
			next_r.st  = hdc_pkg::HDC_ADDR;
			next_r.cnt = 4'h0;
			next_r.drv = 1'b0;
		end else if (stop) begin
			next_r.st  = hdc_pkg::HDC_IDLE;
			next_r.drv = 1'b0;
		end else begin
			case (r.st)
				hdc_pkg::HDC_ADDR, hdc_pkg::HDC_PTR, hdc_pkg::HDC_WDATA: begin
					if (rise) begin
						next_r.sh  = {r.sh[6:0], r.sda_s2};
						next_r.cnt = r.cnt + 4'h1;
					end else if (fall && r.cnt == `HDC_BITS_BYTE) begin
						next_r.drv = 1'b1;
						if (r.st == hdc_pkg::HDC_ADDR) begin
							next_r.rw  = r.sh[0];
							next_r.drv = (r.sh[7:1] == `HDC_DEV_ADDR);
							next_r.st  = (r.sh[7:1] == `HDC_DEV_ADDR) ? hdc_pkg::HDC_ADDR_ACK : hdc_pkg::HDC_IDLE;
						end else if (r.st == hdc_pkg::HDC_PTR) begin
							next_r.ptr = r.sh;
							next_r.st  = hdc_pkg::HDC_PTR_ACK;
						end else begin
							next_r.wr  = 1'b1;
							next_r.st  = hdc_pkg::HDC_WDATA_ACK;
						end
					end
				end
				hdc_pkg::HDC_ADDR_ACK, hdc_pkg::HDC_PTR_ACK, hdc_pkg::HDC_WDATA_ACK: begin
					if (fall) begin
						next_r.cnt = 4'h0;
						next_r.drv = 1'b0;
						if (r.st == hdc_pkg::HDC_WDATA_ACK)
							next_r.ptr = r.ptr + 8'h01;
						if (r.st == hdc_pkg::HDC_ADDR_ACK && r.rw) begin
							next_r.sh  = bus.rd_data;
							next_r.drv = ~bus.rd_data[7];
							next_r.st  = hdc_pkg::HDC_RDATA;
						end else begin
							next_r.st  = (r.st == hdc_pkg::HDC_ADDR_ACK) ? hdc_pkg::HDC_PTR : hdc_pkg::HDC_WDATA;
						end
					end
				end
				hdc_pkg::HDC_RDATA: begin
					if (rise) begin
						next_r.cnt = r.cnt + 4'h1;
					end else if (fall) begin
						if (r.cnt == `HDC_BITS_BYTE) begin
							next_r.drv = 1'b0;
							next_r.st  = hdc_pkg::HDC_RACK;
						end else begin
							next_r.sh  = {r.sh[6:0], 1'b0};
							next_r.drv = ~r.sh[6];
						end
					end
				end
				hdc_pkg::HDC_RACK: begin
					// A not-acknowledge ends the read; the master then sends stop
					if (rise) begin
						if (r.sda_s2)
							next_r.st = hdc_pkg::HDC_IDLE;
						else
							next_r.ptr = r.ptr + 8'h01;
					end else if (fall) begin
						next_r.cnt = 4'h0;
						next_r.sh  = bus.rd_data;
						next_r.drv = ~bus.rd_data[7];
						next_r.st  = hdc_pkg::HDC_RDATA;
					end
				end
				default: begin
					next_r.drv = 1'b0;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			r <= RST;
		else
			r <= next_r;
	end
endmodule

// >>> design/hdc_drive_ctrl.sv
// Function
// - Boost bit raises loop gain during overdrive
// - Bias bit drives common-mode onto input pin
// - Bias bit: 0 off, 1 on, resets 0
// - Resonant mode: field seeds time, then auto-adjusts
// - Resonant time = field x 0.1 ms + 0.5 ms
// - Mass mode: sample period = field x 0.2 ms + 1 ms
// - Amplifier gain code read per mode, calibration fills
`timescale 1ns/1ps
`include "hdc_consts.svh"
module hdc_drive_ctrl (
	input  wire logic        sys_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output wire logic        sda_o,
	output wire logic        sda_oe_o,
	input  wire logic        lra_mode_i,
	input  wire logic        overdrive_i,
	input  wire logic        drive_en_i,
	input  wire logic        period_lengthen_i,
	input  wire logic        period_shorten_i,
	input  wire logic        cal_gain_valid_i,
	input  wire logic [1:0]  cal_gain_i,
	output wire logic        overdrive_gain_boost_o,
	output wire logic        input_bias_enable_o,
	output wire logic [1:0]  backemf_amp_gain_o,
	output wire logic [11:0] backemf_gain_x100_o,
	output wire logic [6:0]  drive_period_steps_o,
	output wire logic        period_tick_o
);
	localparam hdc_pkg::hdc_top_t RST = '{boost: `HDC_BOOST_RST, ac: `HDC_AC_RST, dt: `HDC_DT_RST,
		gain: `HDC_GAIN_RST, gain_x100: `HDC_LRA_GAIN2, running: 1'b0, period: `HDC_PERIOD_MIN,
		step: 11'h000, pcnt: 7'h00, tick: 1'b0};
	localparam logic [10:0] STEP_LAST = 11'(`HDC_STEP_CYC - 1);

	hdc_pkg::hdc_top_t r;
	hdc_pkg::hdc_top_t next_r;
	hdc_regbus_if      bus ();

	// Period in 0.1 ms steps; resonant and mass scales differ
	function automatic logic [6:0] drive_steps(input logic lra, input logic [4:0] f);
		if (lra)
			drive_steps = 7'({2'b00, f} * 7'(`HDC_LRA_UNIT_US / `HDC_STEP_US)) + 7'(`HDC_LRA_BASE_US / `HDC_STEP_US);
		else
			drive_steps = 7'({2'b00, f} * 7'(`HDC_ERM_UNIT_US / `HDC_STEP_US)) + 7'(`HDC_ERM_BASE_US / `HDC_STEP_US);
	endfunction

	// Same code means a different gain per actuator type
	function automatic logic [11:0] gain_scale(input logic lra, input logic [1:0] g);
		case ({lra, g})
			3'h0:    gain_scale = `HDC_ERM_GAIN0;
			3'h1:    gain_scale = `HDC_ERM_GAIN1;
			3'h2:    gain_scale = `HDC_ERM_GAIN2;
			3'h3:    gain_scale = `HDC_ERM_GAIN3;
			3'h4:    gain_scale = `HDC_LRA_GAIN0;
			3'h5:    gain_scale = `HDC_LRA_GAIN1;
			3'h6:    gain_scale = `HDC_LRA_GAIN2;
			default: gain_scale = `HDC_LRA_GAIN3;
		endcase
	endfunction

	hdc_i2c_slave u_i2c (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.scl_i     (scl_i),
		.sda_i     (sda_i),
		.sda_o     (sda_o),
		.sda_oe_o  (sda_oe_o),
		.bus       (bus.master)
	);

	// Readback; unmapped offsets read zero
	assign bus.rd_data = (bus.rd_addr == `HDC_REG_ADDR) ? {r.boost, 1'b0, r.ac, r.dt} : `HDC_RD_UNMAPPED;

	// Boost only acts while the engine is in its overdrive phase
	assign overdrive_gain_boost_o = r.boost & overdrive_i;
	assign input_bias_enable_o    = r.ac;
	assign backemf_amp_gain_o     = r.gain;
	assign backemf_gain_x100_o    = r.gain_x100;
	assign drive_period_steps_o   = r.period;
	assign period_tick_o          = r.tick;

	// Register writes, calibration and the drive-period timer
	always_comb begin
		next_r      = r;
		next_r.tick = 1'b0;
		if (bus.wr_valid && bus.wr_addr == `HDC_REG_ADDR) begin
			next_r.boost = bus.wr_data[`HDC_BOOST_BIT];
			next_r.ac    = bus.wr_data[`HDC_AC_BIT];
			next_r.dt    = bus.wr_data[`HDC_DT_MSB:0];
		end
		if (cal_gain_valid_i)
			next_r.gain = cal_gain_i;
		next_r.gain_x100 = gain_scale(lra_mode_i, next_r.gain);
		next_r.running   = drive_en_i;
		if (drive_en_i && !r.running) begin
			// Field is only a seed; later writes do not disturb a running resonant loop
			next_r.period = drive_steps(lra_mode_i, r.dt);
			next_r.step   = 11'h000;
			next_r.pcnt   = 7'h00;
		end else if (drive_en_i) begin
			if (lra_mode_i && period_lengthen_i && !period_shorten_i && r.period != `HDC_PERIOD_MAX)
				next_r.period = r.period + 7'h01;
			else if (lra_mode_i && period_shorten_i && !period_lengthen_i && r.period != `HDC_PERIOD_MIN)
				next_r.period = r.period - 7'h01;
			if (r.step == STEP_LAST) begin
				next_r.step = 11'h000;
				if (r.pcnt >= r.period - 7'h01) begin
					next_r.pcnt = 7'h00;
					next_r.tick = 1'b1;
					if (!lra_mode_i)
						next_r.period = drive_steps(1'b0, r.dt);
				end else begin
					next_r.pcnt = r.pcnt + 7'h01;
				end
			end else begin
				next_r.step = r.step + 11'h001;
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			r <= RST;
		else
			r <= next_r;
	end

	// Checker helper: no write has reached the register yet
	logic fresh;
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			fresh <= 1'b1;
		else if (bus.wr_valid && bus.wr_addr == `HDC_REG_ADDR)
			fresh <= 1'b0;
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_reg_wr;
		bus.wr_valid && bus.wr_addr == `HDC_REG_ADDR;
	endsequence

	sequence s_start(lra);
		!r.running && drive_en_i && lra_mode_i == lra;
	endsequence

	// Last cycle of a whole period while the timer runs
	sequence s_period_end(lra);
		r.running && drive_en_i && lra_mode_i == lra && r.step == STEP_LAST && r.pcnt >= r.period - 7'h01;
	endsequence

	// Boost follows the written bit once overdrive is active
	a_boost_gate: assert property ((s_reg_wr ##1 overdrive_i) |->
		overdrive_gain_boost_o == $past(bus.wr_data[`HDC_BOOST_BIT])) else $error("boost not gated by register");

	// Outside overdrive the extra gain must never show
	a_boost_idle: assert property (!overdrive_i |-> !overdrive_gain_boost_o)
		else $error("boost active outside overdrive");

	// Bias enable takes the written bit
	a_bias_write: assert property (s_reg_wr |=> input_bias_enable_o == $past(bus.wr_data[`HDC_AC_BIT]))
		else $error("bias enable does not follow write");

	// Only a register write may move the bias enable
	a_bias_hold: assert property (!(bus.wr_valid && bus.wr_addr == `HDC_REG_ADDR) |=>
		$stable(input_bias_enable_o)) else $error("bias enable moved without write");

	// Until the first write the bias stays off and the field keeps its reset value
	a_bias_reset: assert property (fresh |->
		!input_bias_enable_o && (bus.rd_data[5:0] == 6'h13 || bus.rd_addr != `HDC_REG_ADDR))
		else $error("bias enable not zero after reset");

	// Resonant seed is field plus five steps
	a_lra_seed: assert property (s_start(1'b1) |=> drive_period_steps_o == 7'($past(r.dt)) + 7'h05)
		else $error("resonant seed period wrong");

	// Mass sample period is twice the field plus ten steps
	a_erm_seed: assert property (s_start(1'b0) |=>
		drive_period_steps_o == 7'({2'b00, $past(r.dt)} * 2) + 7'h0a) else $error("sample period wrong");

	// Mass mode reloads the sample period at every period end
	a_erm_reload: assert property (s_period_end(1'b0) |=>
		drive_period_steps_o == 7'({2'b00, $past(r.dt)} * 2) + 7'h0a) else $error("sample period not reloaded");

	// Lengthen pulse grows a running resonant period by one step
	a_lra_adjust: assert property (r.running && drive_en_i && lra_mode_i && period_lengthen_i &&
		!period_shorten_i && r.period != `HDC_PERIOD_MAX |=> drive_period_steps_o == $past(r.period) + 7'h01)
		else $error("resonant period not adjusted");

	// Shorten pulse trims a running resonant period by one step
	a_lra_shorten: assert property (r.running && drive_en_i && lra_mode_i && period_shorten_i &&
		!period_lengthen_i && r.period != `HDC_PERIOD_MIN |=> drive_period_steps_o == $past(r.period) - 7'h01)
		else $error("resonant period not shortened");

	// Both pulses at once cancel out
	a_adjust_both: assert property (r.running && drive_en_i && lra_mode_i && period_lengthen_i &&
		period_shorten_i |=> $stable(drive_period_steps_o)) else $error("conflicting pulses moved period");

	// Mass mode ignores the resonant adjust pulses
	a_erm_fixed: assert property (r.running && drive_en_i && !lra_mode_i && r.step != STEP_LAST &&
		(period_lengthen_i || period_shorten_i) |=> $stable(drive_period_steps_o)) else $error("mass period adjusted");

	// A full resonant period ends in a tick
	a_lra_tick: assert property (s_period_end(1'b1) |=> period_tick_o)
		else $error("period end without tick");

	// Tick is a single-cycle pulse
	a_tick_pulse: assert property (period_tick_o |=> !period_tick_o)
		else $error("tick longer than one cycle");

	// Saturation keeps the period from reaching zero
	a_period_floor: assert property (drive_period_steps_o != 7'h00)
		else $error("drive period reached zero");

	// Calibration loads the gain code
	a_gain_load: assert property (cal_gain_valid_i |=> backemf_amp_gain_o == $past(cal_gain_i))
		else $error("calibration gain not loaded");

	// Code two means twenty times in resonant mode
	a_gain_mode: assert property (lra_mode_i && !cal_gain_valid_i && backemf_amp_gain_o == 2'h2 |=>
		backemf_gain_x100_o == 12'h7d0) else $error("resonant gain scale wrong");

	// Code zero means a third in mass mode
	a_gain_erm: assert property (!lra_mode_i && !cal_gain_valid_i && backemf_amp_gain_o == 2'h0 |=>
		backemf_gain_x100_o == 12'h021) else $error("mass gain scale wrong");

	// Reserved bit reads zero right after a write
	a_rsvd_zero: assert property ((s_reg_wr ##1 bus.rd_addr == `HDC_REG_ADDR) |->
		bus.rd_data[6] == 1'b0) else $error("reserved bit reads nonzero");

	// Every other offset reads as zero
	a_rd_map: assert property (bus.rd_addr != `HDC_REG_ADDR |-> bus.rd_data == `HDC_RD_UNMAPPED)
		else $error("unmapped offset reads nonzero");
endmodule

// >>> test/hdc_host_model.sv
`timescale 1ns/1ps
`include "hdc_consts.svh"
module hdc_host_model (
	input  wire logic sys_clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	// Bus idles released; the pull-up holds both lines high
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	// Moves land just after an edge so the device sync never races them
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk_i);
		#5;
	endtask
	// Data moves mid-low, so a START or STOP is never seen by mistake
	task automatic bit_x(input logic b, output logic s);
		scl_o = 1'b0;
		wt(4);
		sda_low_o = ~b;
		wt(4);
		scl_o = 1'b1;
		wt(8);
		s = sda_i;
	endtask
	// Also serves as repeated START
	task automatic start();
		bit_x(1'b1, sda_low_o);
		sda_low_o = 1'b1;
		wt(8);
		scl_o = 1'b0;
	endtask
	task automatic stop();
		bit_x(1'b0, sda_low_o);
		sda_low_o = 1'b0;
		wt(8);
	endtask
	task automatic tx(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_x(b[i], s);
		bit_x(1'b1, s);
		ack = ~s;
	endtask
	task automatic rx(output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
		bit_x(1'b1, s);
	endtask
	task automatic write_reg(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d, output logic ok);
		logic a0, a1, a2;
		start();
		tx({dev, 1'b0}, a0);
		tx(p, a1);
		tx(d, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask
	// Pointer write, repeated START, one byte read and NACKed
	task automatic read_reg(input logic [7:0] p, output logic [7:0] d, output logic ok);
		logic a0, a1, a2;
		start();
		tx({`HDC_DEV_ADDR, 1'b0}, a0);
		tx(p, a1);
		start();
		tx({`HDC_DEV_ADDR, 1'b1}, a2);
		rx(d);
		stop();
		ok = a0 & a1 & a2;
	endtask
endmodule

// >>> test/hdc_drive_ctrl_bench.sv
`timescale 1ns/1ps
`include "hdc_consts.svh"
module hdc_drive_ctrl_bench;
	logic        sys_clk_i, resetn_i, lra, od, en, lng, shr, cv;
	logic [1:0]  cg;
	logic [7:0]  lf;
	wire logic   scl, sda_low, sda_o, sda_oe, boost, bias, tick;
	wire logic [1:0]  gain;
	wire logic [11:0] x100;
	wire logic [6:0]  per;
	int          n_mismatch = 0;
	int          checked = 0;
	logic [7:0]  m_reg = 8'h93;
	logic [11:0] etab [4] = '{12'h021, 12'h064, 12'h0b4, 12'h190};
	logic [11:0] ltab [4] = '{12'h1f4, 12'h3e8, 12'h7d0, 12'hbb8};
	// Open-drain line with pull-up
	wire logic   sda_line = ~sda_low & ~(sda_oe & ~sda_o);

	hdc_drive_ctrl hdc_drive_ctrl_inst (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_line),
		.sda_o(sda_o), .sda_oe_o(sda_oe), .lra_mode_i(lra), .overdrive_i(od), .drive_en_i(en),
		.period_lengthen_i(lng), .period_shorten_i(shr), .cal_gain_valid_i(cv), .cal_gain_i(cg),
		.overdrive_gain_boost_o(boost), .input_bias_enable_o(bias), .backemf_amp_gain_o(gain),
		.backemf_gain_x100_o(x100), .drive_period_steps_o(per), .period_tick_o(tick));
	hdc_host_model hdc_host_model_inst (.sys_clk_i(sys_clk_i), .sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));

	// Clock at 50 ns
	initial begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
		#5;
	endtask
	// Model keeps the register; bit 6 never stored
	task automatic wreg(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d);
		logic ok;
		hdc_host_model_inst.write_reg(dev, p, d, ok);
		chk(16'(ok), 16'(dev == `HDC_DEV_ADDR));
		if (dev == `HDC_DEV_ADDR && p == `HDC_REG_ADDR) m_reg = d & 8'hbf;
	endtask
	task automatic rreg(input logic [7:0] p);
		logic [7:0] d;
		logic ok;
		hdc_host_model_inst.read_reg(p, d, ok);
		chk(16'(ok), 16'h1);
		chk(16'(d), (p == `HDC_REG_ADDR) ? 16'(m_reg) : 16'h0);
	endtask
	// Tolerance of one cycle covers where the seed edge is counted
	task automatic wait_tick(input int exp);
		int n;
		n = 0;
		while (tick !== 1'b1 && n < exp + 10) begin
			cyc(1);
			n++;
		end
		chk(16'((n >= exp - 1 && n <= exp + 1) ? exp : n), 16'(exp));
	endtask
	task automatic tally_and_finish();
		if (n_mismatch == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		{resetn_i, od, en, lng, shr, cv, cg} = '0;
		lra = 1'b1;
		lf = 8'h0b;
		cyc(20);
		resetn_i = 1'b1;
		cyc(4);
		chk(16'(bias), 16'h0);
		chk(16'(gain), 16'h2);
		chk(16'(x100), 16'h7d0);
		chk(16'(per), 16'h1);
		rreg(8'h1b);
		for (int i = 0; i < 5; i++) begin
			lf = lfsr(lf);
			// Overdrive held through the write so the boost path is exercised live
			od = 1'b1;
			wreg(`HDC_DEV_ADDR, 8'h1b, (i == 4) ? 8'h7f : lf);
			rreg(8'h1b);
			chk(16'(bias), 16'(m_reg[5]));
			chk(16'(boost), 16'(m_reg[7]));
			od = 1'b0;
			cyc(1);
			chk(16'(boost), 16'h0);
		end
		wreg(7'h2d, 8'h1b, 8'h00);
		wreg(`HDC_DEV_ADDR, 8'h1c, 8'h55);
		rreg(8'h1b);
		rreg(8'h1c);
		for (int m = 0; m < 2; m++) for (int g = 0; g < 4; g++) begin
			lra = m[0];
			cg = g[1:0];
			cv = 1'b1;
			cyc(1);
			cv = 1'b0;
			cyc(2);
			chk(16'(gain), 16'(g));
			chk(16'(x100), 16'(m ? ltab[g] : etab[g]));
		end
		wreg(`HDC_DEV_ADDR, 8'h1b, 8'h81);
		lra = 1'b1;
		cyc(1);
		en = 1'b1;
		wait_tick(2000 * 6 + 1);
		chk(16'(per), 16'h6);
		shr = 1'b1;
		cyc(7);
		shr = 1'b0;
		cyc(1);
		chk(16'(per), 16'h1);
		{lng, shr} = 2'h2;
		cyc(2);
		{lng, shr} = 2'h3;
		cyc(1);
		{lng, shr} = 2'h0;
		cyc(1);
		chk(16'(per), 16'h3);
		en = 1'b0;
		lra = 1'b0;
		cyc(2);
		en = 1'b1;
		wait_tick(2000 * 12 + 1);
		lng = 1'b1;
		cyc(1);
		lng = 1'b0;
		cyc(1);
		chk(16'(per), 16'hc);
		en = 1'b0;
		tally_and_finish();
	end
	// Watchdog: the run needs roughly 45000 cycles
	initial begin
		#(50 * 100000);
		n_mismatch++;
		tally_and_finish();
	end
endmodule
